// ==== hdl/jdt_pkg.sv ====
package jdt_pkg;
  localparam int IR_W = 5;
  localparam logic [4:0] IR_IDCODE = 5'h01;
  localparam logic [4:0] IR_CTRL = 5'h10;
  localparam logic [4:0] IR_LINK = 5'h11;
  localparam logic [4:0] IR_RESET = 5'h01;
  localparam int LINK_ADDR_W = 7;
  localparam int LINK_DATA_W = 32;
  localparam int LINK_W = 41;
  localparam int CTRL_W = 32;
  localparam int ID_W = 32;
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_BUSY = 2'h3;
  localparam logic [1:0] STAT_OK = 2'h0;
  localparam logic [1:0] STAT_FAIL = 2'h2;
  localparam logic [1:0] STAT_BUSY = 2'h3;
  localparam int CTRL_HARDRST_BIT = 17;
  localparam int CTRL_ERRCLR_BIT = 16;
  localparam logic [2:0] CTRL_IDLE = 3'h0;
  localparam logic [5:0] CTRL_ABITS = 6'h07;
  localparam logic [3:0] CTRL_VERSION = 4'h1;
  // identification fields; values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5a5a;
  localparam logic [10:0] ID_MAKER = 11'h123;
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR, TS_PAUSE_DR,
    TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EXIT1_IR,
    TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
  } jdt_tap_e;
endpackage

// ==== hdl/jdt_link_if.sv ====
interface jdt_link_if;
  logic req;
  logic wr;
  logic [6:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  logic busy;
  modport port_side (output req, output wr, output addr, output wdata,
    input ack, input rdata, input busy);
  modport ctl_side (input req, input wr, input addr, input wdata,
    output ack, output rdata, output busy);
endinterface

// ==== hdl/jdt_sync.sv ====
module jdt_sync (
  // clock
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out
);
  logic [3:0] meta_r;
  // two stages; first stage read only by second
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle levels: tap reset released, tck low, tms high
      meta_r <= 4'ha;
      pin_out <= 4'ha;
    end else begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end
endmodule

// ==== hdl/jdt_tap.sv ====
// Function
// RQ1 - optional active-low tap reset, tie high
// RQ2 - all pins oversampled on processor clock
// RQ3 - debugger keeps tck at most clk/5
// RQ4 - debugger excluded: tdi passes to tdo
// RQ5 - no boundary scan, pins unreachable
// RQ6 - five-bit instruction register selects data
// RQ7 - code 00001 selects 32-bit identification
// RQ8 - code 10000 selects control status register
// RQ9 - code 10001 selects 41-bit link register
// RQ10 - other codes select one-bit bypass
// RQ11 - bits 31:18 and 15 read zero
// RQ12 - bit 17 resets link, self-clears
// RQ13 - bit 16 clears sticky error, self-clears
// RQ14 - bits 14:12 read zero, no idle
// RQ15 - bits 11:10 report link status
// RQ16 - bits 9:4 read seven
// RQ17 - bits 3:0 read 0001
// RQ18 - link reads/writes forwarded to debug controller
// RQ19 - unimplemented addresses: ignored, read zero
// RQ20 - standard sixteen-state tap, tdo on fall
module jdt_tap #(
  parameter bit DEBUG_EN = 1'b1,
  parameter logic [3:0] ID_VER = jdt_pkg::ID_VERSION,
  parameter logic [15:0] ID_PRT = jdt_pkg::ID_PART,
  parameter logic [10:0] ID_MFR = jdt_pkg::ID_MAKER
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // jtag pins
  input wire logic tap_rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // debug controller link
  output logic link_req,
  output logic link_wr,
  output logic [6:0] link_addr,
  output logic [31:0] link_wdata,
  input wire logic link_ack,
  input wire logic [31:0] link_rdata,
  output logic link_reset
);
  jdt_link_if lnk();
  logic [3:0] pins_s;
  logic tck_prev_r;
  // RQ2 - pin oversampling
  jdt_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({tap_rst_n, tck, tms, tdi}),
    .pin_out(pins_s)
  );
  wire trst_n_s = pins_s[3];
  wire tck_s = pins_s[2];
  wire tms_s = pins_s[1];
  wire tdi_s = pins_s[0];
  wire tck_rise = tck_s & ~tck_prev_r;
  wire tck_fall = ~tck_s & tck_prev_r;

  jdt_pkg::jdt_tap_e st_r, st_nxt;
  logic [4:0] ir_r, ir_sh_r;
  logic [40:0] dr_r;
  logic [1:0] stat_r;
  logic busy_r;
  logic [31:0] rd_hold_r;
  logic tdo_r;
  logic hardrst_r;

  // RQ20 - state transitions
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      jdt_pkg::TS_RESET: st_nxt = tms_s ? jdt_pkg::TS_RESET : jdt_pkg::TS_IDLE;
      jdt_pkg::TS_IDLE: st_nxt = tms_s ? jdt_pkg::TS_SEL_DR : jdt_pkg::TS_IDLE;
      jdt_pkg::TS_SEL_DR: st_nxt = tms_s ? jdt_pkg::TS_SEL_IR : jdt_pkg::TS_CAP_DR;
      jdt_pkg::TS_CAP_DR: st_nxt = tms_s ? jdt_pkg::TS_EXIT1_DR : jdt_pkg::TS_SHIFT_DR;
      jdt_pkg::TS_SHIFT_DR: st_nxt = tms_s ? jdt_pkg::TS_EXIT1_DR : jdt_pkg::TS_SHIFT_DR;
      jdt_pkg::TS_EXIT1_DR: st_nxt = tms_s ? jdt_pkg::TS_UPD_DR : jdt_pkg::TS_PAUSE_DR;
      jdt_pkg::TS_PAUSE_DR: st_nxt = tms_s ? jdt_pkg::TS_EXIT2_DR : jdt_pkg::TS_PAUSE_DR;
      jdt_pkg::TS_EXIT2_DR: st_nxt = tms_s ? jdt_pkg::TS_UPD_DR : jdt_pkg::TS_SHIFT_DR;
      jdt_pkg::TS_UPD_DR: st_nxt = tms_s ? jdt_pkg::TS_SEL_DR : jdt_pkg::TS_IDLE;
      jdt_pkg::TS_SEL_IR: st_nxt = tms_s ? jdt_pkg::TS_RESET : jdt_pkg::TS_CAP_IR;
      jdt_pkg::TS_CAP_IR: st_nxt = tms_s ? jdt_pkg::TS_EXIT1_IR : jdt_pkg::TS_SHIFT_IR;
      jdt_pkg::TS_SHIFT_IR: st_nxt = tms_s ? jdt_pkg::TS_EXIT1_IR : jdt_pkg::TS_SHIFT_IR;
      jdt_pkg::TS_EXIT1_IR: st_nxt = tms_s ? jdt_pkg::TS_UPD_IR : jdt_pkg::TS_PAUSE_IR;
      jdt_pkg::TS_PAUSE_IR: st_nxt = tms_s ? jdt_pkg::TS_EXIT2_IR : jdt_pkg::TS_PAUSE_IR;
      jdt_pkg::TS_EXIT2_IR: st_nxt = tms_s ? jdt_pkg::TS_UPD_IR : jdt_pkg::TS_SHIFT_IR;
      jdt_pkg::TS_UPD_IR: st_nxt = tms_s ? jdt_pkg::TS_SEL_DR : jdt_pkg::TS_IDLE;
    endcase
  end

  // RQ1 - tap reset pin forces reset state
  wire tap_hold = ~trst_n_s;
  always_ff @(posedge clk) begin
    if (rst || tap_hold) begin
      st_r <= jdt_pkg::TS_RESET;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= tck_s;
    end
  end

  // RQ6 - register selection decode
  wire sel_id = (ir_r == jdt_pkg::IR_IDCODE);
  // RQ8 - control status select
  wire sel_ctrl = (ir_r == jdt_pkg::IR_CTRL);
  wire sel_link = (ir_r == jdt_pkg::IR_LINK);
  // RQ10 - anything else is bypass
  wire sel_byp = ~(sel_id | sel_ctrl | sel_link);

  // RQ7 - identification value from parameters
  wire [31:0] id_val = {ID_VER, ID_PRT, ID_MFR, 1'b1};
  // RQ11 - reserved bits zero; RQ14 idle zero; RQ16 abits; RQ17 version
  wire [31:0] ctrl_val = {14'h0, 2'h0, 1'b0, jdt_pkg::CTRL_IDLE, stat_r,
    jdt_pkg::CTRL_ABITS, jdt_pkg::CTRL_VERSION};
  // RQ15 - busy reported while a request is outstanding
  wire [1:0] op_cap = (stat_r != jdt_pkg::STAT_OK) ? stat_r :
    (busy_r ? jdt_pkg::OP_BUSY : jdt_pkg::OP_NOP);
  wire [40:0] link_cap = {link_addr, rd_hold_r, op_cap};
  wire [40:0] cap_val = sel_link ? link_cap :
    sel_ctrl ? {9'h0, ctrl_val} :
    sel_id ? {9'h0, id_val} : 41'h0;
  // shift length depends on selection
  wire [40:0] dr_shift = sel_link ? {tdi_s, dr_r[40:1]} :
    (sel_ctrl | sel_id) ? {9'h0, tdi_s, dr_r[31:1]} : {40'h0, tdi_s};
  wire in_shift_dr = (st_r == jdt_pkg::TS_SHIFT_DR);
  wire in_shift_ir = (st_r == jdt_pkg::TS_SHIFT_IR);
  wire upd_dr = tck_rise && (st_r == jdt_pkg::TS_UPD_DR);
  // RQ9 - link operation decode
  wire [1:0] new_op = dr_r[1:0];
  wire op_valid = (new_op == jdt_pkg::OP_READ) || (new_op == jdt_pkg::OP_WRITE);
  wire new_req = upd_dr && sel_link && op_valid;

  // RQ20 - capture, shift, update on rising tck
  always_ff @(posedge clk) begin
    if (rst || tap_hold) begin
      ir_r <= jdt_pkg::IR_IDCODE;
      ir_sh_r <= 5'h0;
      dr_r <= 41'h0;
    end else if (tck_rise) begin
      unique case (st_r)
        jdt_pkg::TS_RESET: ir_r <= jdt_pkg::IR_IDCODE;
        jdt_pkg::TS_CAP_IR: ir_sh_r <= 5'h01;
        jdt_pkg::TS_SHIFT_IR: ir_sh_r <= {tdi_s, ir_sh_r[4:1]};
        jdt_pkg::TS_UPD_IR: ir_r <= ir_sh_r;
        jdt_pkg::TS_CAP_DR: dr_r <= cap_val;
        jdt_pkg::TS_SHIFT_DR: dr_r <= dr_shift;
        default: ;
      endcase
    end
  end

  // RQ20 - tdo changes on falling tck
  wire tdo_bit = in_shift_ir ? ir_sh_r[0] : (in_shift_dr ? dr_r[0] : 1'b0);
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_bit;
    end
  end
  // RQ4 - chain kept when debugger excluded; RQ5 no scan cells exist
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo <= 1'b0;
    end else begin
      tdo <= DEBUG_EN ? tdo_r : tdi_s;
    end
  end

  // RQ12 - hard reset bit, self-clearing pulse
  wire ctrl_upd = upd_dr && sel_ctrl;
  wire hard_hit = ctrl_upd && dr_r[jdt_pkg::CTRL_HARDRST_BIT];
  // RQ13 - error clear bit, self-clearing
  wire err_clr = ctrl_upd && dr_r[jdt_pkg::CTRL_ERRCLR_BIT];
  // RQ15 - request while pending is sticky busy error
  wire err_busy = upd_dr && sel_link && busy_r && (new_op != jdt_pkg::OP_NOP);
  wire err_fail = upd_dr && sel_link && (new_op == jdt_pkg::OP_BUSY);

  always_ff @(posedge clk) begin
    if (rst) begin
      hardrst_r <= 1'b0;
    end else begin
      hardrst_r <= hard_hit;
    end
  end
  assign link_reset = hardrst_r;

  // status: set beats clear
  always_ff @(posedge clk) begin
    if (rst || hardrst_r) begin
      stat_r <= jdt_pkg::STAT_OK;
    end else if (err_busy && stat_r == jdt_pkg::STAT_OK) begin
      stat_r <= jdt_pkg::STAT_BUSY;
    end else if (err_fail && stat_r == jdt_pkg::STAT_OK) begin
      stat_r <= jdt_pkg::STAT_FAIL;
    end else if (err_clr) begin
      stat_r <= jdt_pkg::STAT_OK;
    end
  end

  // RQ18 - forward link request; busy blocks new ones
  wire launch = new_req && !busy_r && (stat_r == jdt_pkg::STAT_OK);
  always_ff @(posedge clk) begin
    if (rst || hardrst_r) begin
      busy_r <= 1'b0;
      link_req <= 1'b0;
      link_wr <= 1'b0;
      link_addr <= 7'h0;
      link_wdata <= 32'h0;
      rd_hold_r <= 32'h0;
    end else if (launch) begin
      busy_r <= 1'b1;
      link_req <= 1'b1;
      link_wr <= (new_op == jdt_pkg::OP_WRITE);
      link_addr <= dr_r[40:34];
      link_wdata <= dr_r[33:2];
    end else if (busy_r && link_ack) begin
      busy_r <= 1'b0;
      link_req <= 1'b0;
      // RQ19 - controller answers zero for unmapped reads
      rd_hold_r <= link_wr ? rd_hold_r : link_rdata;
    end
  end

  assign lnk.req = link_req;
  assign lnk.wr = link_wr;
  assign lnk.addr = link_addr;
  assign lnk.wdata = link_wdata;
  assign lnk.ack = link_ack;
  assign lnk.rdata = link_rdata;
  assign lnk.busy = busy_r;

  // assertions
  a_req_holds: assert property (@(posedge clk) disable iff (rst)
    link_req && !link_ack && !hardrst_r |=> link_req) // RQ18
    else $error("link request dropped before ack");
  a_hard_pulse: assert property (@(posedge clk) disable iff (rst)
    hard_hit |=> link_reset ##1 !link_req) // RQ12
    else $error("hard reset not applied");
  a_clr_status: assert property (@(posedge clk) disable iff (rst)
    err_clr && !err_busy && !err_fail |=> stat_r == jdt_pkg::STAT_OK) // RQ13
    else $error("error clear ignored");
  a_busy_sticky: assert property (@(posedge clk) disable iff (rst)
    err_busy && !hardrst_r && stat_r == jdt_pkg::STAT_OK |=> stat_r == jdt_pkg::STAT_BUSY) // RQ15
    else $error("busy error not recorded");
  a_tap_reset: assert property (@(posedge clk) disable iff (rst)
    tap_hold |=> st_r == jdt_pkg::TS_RESET && ir_r == jdt_pkg::IR_IDCODE) // RQ1
    else $error("tap reset not honoured");
  a_five_tms: assert property (@(posedge clk) disable iff (rst || tap_hold)
    st_r == jdt_pkg::TS_SEL_IR && tms_s && tck_rise |=> st_r == jdt_pkg::TS_RESET) // RQ20
    else $error("select ir with tms high must reset");
  a_tdo_fall: assert property (@(posedge clk) disable iff (rst)
    !tck_fall |=> tdo_r == $past(tdo_r)) // RQ20
    else $error("tdo changed off falling edge");
  a_ctrl_const: assert property (@(posedge clk) disable iff (rst)
    ctrl_val[9:0] == 10'h071 && ctrl_val[31:18] == 14'h0 && !ctrl_val[15]) // RQ16
    else $error("control constant fields wrong");
  a_bypass_len: assert property (@(posedge clk) disable iff (rst)
    sel_byp && in_shift_dr && tck_rise && !tap_hold |=> dr_r[40:1] == 40'h0) // RQ10
    else $error("bypass wider than one bit");
  c_link_write: cover property (@(posedge clk) launch && new_op == jdt_pkg::OP_WRITE);
  c_link_read: cover property (@(posedge clk) launch && new_op == jdt_pkg::OP_READ);
  c_busy_err: cover property (@(posedge clk) err_busy);
  c_ir_update: cover property (@(posedge clk) tck_rise && st_r == jdt_pkg::TS_UPD_IR);
endmodule

// ==== tb/jdt_ctl_model.sv ====
module jdt_ctl_model (
  // clock
  input wire logic clk,
  // link
  input wire logic link_req,
  input wire logic link_wr,
  input wire logic [6:0] link_addr,
  input wire logic [31:0] link_wdata,
  output logic link_ack,
  output logic [31:0] link_rdata,
  // test control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_r = 32'h0;
  initial begin
    link_ack = 1'b0;
    link_rdata = 32'h0;
    forever begin
      @(posedge clk);
      link_ack <= 1'b0;
      // toggles when idle so stale data never matches
      link_rdata <= ~link_rdata;
      if (link_req && !link_ack) begin
        repeat (slow ? 900 : 3) @(posedge clk);
        link_ack <= 1'b1;
        link_rdata <= (link_addr == 7'h04) ? mem_r : 32'h0;
        if (link_wr && link_addr == 7'h04) mem_r <= link_wdata;
      end
    end
  end
endmodule

// ==== tb/tb_jdt_tap.sv ====
module tb_jdt_tap;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, tap_rst_n, tck, tms, tdi, tdo, tdo_off, slow, q;
  logic link_req, link_wr, link_ack, link_reset;
  logic link_req_d = 1'b0;
  logic [6:0] link_addr, a;
  logic [31:0] link_wdata, link_rdata, rnd;
  logic [39:0] link_seen;
  logic [40:0] seen_dr;
  logic [40:0] exp_q[$];
  logic [39:0] link_q[$];
  logic [4:0] byp[3] = '{5'h00, 5'h1f, 5'h12};
  int errors = 0;
  int cmp_count = 0;
  event scan_ev;
  localparam logic [31:0] ID_VAL = {jdt_pkg::ID_VERSION, jdt_pkg::ID_PART,
    jdt_pkg::ID_MAKER, 1'b1};
  localparam logic [40:0] CTRL0 = 41'h71;

  jdt_tap jdt_tap_inst (.clk(clk), .rst(rst), .tap_rst_n(tap_rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_ack(link_ack), .link_rdata(link_rdata),
    .link_reset(link_reset));
  jdt_tap #(.DEBUG_EN(1'b0)) jdt_tap_off_inst (.clk(clk), .rst(rst), .tap_rst_n(tap_rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_off), .link_req(), .link_wr(), .link_addr(),
    .link_wdata(), .link_ack(1'b0), .link_rdata(32'h0), .link_reset());
  jdt_ctl_model jdt_ctl_model_inst (.clk(clk), .link_req(link_req), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_ack(link_ack),
    .link_rdata(link_rdata), .slow(slow));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // tck runs at one eighth of clk
  task automatic bit_io(input logic m, input logic di, output logic qo);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= di;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (2) @(posedge clk);
    qo = tdo;
    check("passthru", {40'h0, tdo_off}, {40'h0, tdi});
    @(posedge clk);
  endtask

  task automatic scan(input logic ir, input int n, input logic [40:0] din,
                      input logic [40:0] dexp, input int nchk);
    logic [40:0] got, msk;
    got = 41'h0;
    msk = (41'h1 << nchk) - 41'h1;
    bit_io(1'b1, 1'b0, q);
    if (ir)
      bit_io(1'b1, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], q);
      got[i] = q;
    end
    bit_io(1'b1, 1'b0, q);
    bit_io(1'b0, 1'b0, q);
    @(posedge clk);
    tck <= 1'b0;
    if (nchk > 0) begin
      exp_q.push_back(dexp & msk);
      seen_dr = got & msk;
      ->scan_ev;
    end
  endtask

  initial begin
    forever begin
      @(scan_ev);
      check("scan", seen_dr, exp_q.pop_front());
    end
  end

  assign link_seen = link_reset ? 40'hff_ffff_ffff :
    {link_wr, link_addr, link_wr ? link_wdata : 32'h0};
  always @(posedge clk) begin
    link_req_d <= link_req;
    if (!rst && ((link_req && !link_req_d) || link_reset)) begin
      if (link_q.size() == 0)
        check("link spare", 41'h1, 41'h0);
      else
        check("link", {1'b0, link_seen}, {1'b0, link_q.pop_front()});
    end
  end

  initial begin
    rst = 1'b1;
    tap_rst_n = 1'b1;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    slow = 1'b0;
    rnd = 32'h96e1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++)
      bit_io(i < 5, 1'b0, q);
    scan(1'b0, 32, 41'h0, {9'h0, ID_VAL}, 32);
    scan(1'b1, 5, {36'h0, jdt_pkg::IR_CTRL}, 41'h0, 0);
    link_q.push_back(40'hff_ffff_ffff);
    scan(1'b0, 32, 41'hffffffff, CTRL0, 32);
    scan(1'b0, 32, 41'h0, CTRL0, 32);
    scan(1'b1, 5, {36'h0, jdt_pkg::IR_LINK}, 41'h0, 0);
    for (int k = 0; k < 3; k++) begin
      a = (k == 2) ? 7'h33 : 7'h04;
      rnd = lfsr(rnd);
      link_q.push_back({1'b1, a, rnd});
      scan(1'b0, 41, {a, rnd, jdt_pkg::OP_WRITE}, 41'h0, 0);
      link_q.push_back({1'b0, a, 32'h0});
      scan(1'b0, 41, {a, rnd, jdt_pkg::OP_READ}, 41'h0, 2);
      scan(1'b0, 41, 41'h0, {7'h0, (k == 2) ? 32'h0 : rnd, 2'b00}, 34);
    end
    slow <= 1'b1;
    rnd = lfsr(rnd);
    link_q.push_back({1'b1, 7'h04, rnd});
    scan(1'b0, 41, {7'h04, rnd, jdt_pkg::OP_WRITE}, 41'h0, 0);
    scan(1'b0, 41, {7'h04, rnd, jdt_pkg::OP_WRITE}, 41'h0, 0);
    scan(1'b1, 5, {36'h0, jdt_pkg::IR_CTRL}, 41'h0, 0);
    scan(1'b0, 32, 41'h0, 41'hc71, 32);
    for (int i = 0; i < 2000 && link_req; i++)
      @(posedge clk);
    if (link_req !== 1'b0)
      errors++;
    slow <= 1'b0;
    scan(1'b0, 32, 41'h10000, 41'hc71, 32);
    scan(1'b1, 5, {36'h0, jdt_pkg::IR_LINK}, 41'h0, 0);
    scan(1'b0, 41, {39'h0, jdt_pkg::OP_BUSY}, 41'h0, 2);
    scan(1'b1, 5, {36'h0, jdt_pkg::IR_CTRL}, 41'h0, 0);
    link_q.push_back(40'hff_ffff_ffff);
    scan(1'b0, 32, 41'h20000, 41'h871, 32);
    scan(1'b0, 32, 41'h0, CTRL0, 32);
    foreach (byp[j]) begin
      scan(1'b1, 5, {36'h0, byp[j]}, 41'h0, 0);
      scan(1'b0, 2, 41'h3, 41'h2, 2);
    end
    tap_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    tap_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bit_io(1'b0, 1'b0, q);
    // select-ir with tms high back to reset
    for (int i = 0; i < 4; i++)
      bit_io(i < 3, 1'b0, q);
    scan(1'b0, 32, 41'h0, {9'h0, ID_VAL}, 32);
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0 || link_q.size() != 0)
      errors++;
    finish_test();
  end
endmodule
